/* File: rtl/rtc_control_reg.sv */
`timescale 1ns/10ps
`default_nettype none
module rtc_control_reg (
    input  wire logic                     clk_sys,
    input  wire logic                     rst_n,
    input  wire logic                     wb_cyc_i,
    input  wire logic                     wb_stb_i,
    input  wire logic                     wb_we_i,
    input  wire logic [rtc_pkg::ADDR_W-1:0] wb_adr_i,
    input  wire logic [3:0]               wb_sel_i,
    input  wire logic [31:0]              wb_dat_i,
    output var  logic [31:0]              wb_dat_o,
    output var  logic                     wb_ack_o,
    input  wire logic                     protocol_select,
    input  wire logic                     cmd_valid_a,
    input  wire logic                     cmd_valid_b,
    input  wire logic                     broadcast_rx,
    input  wire logic                     rx_end_event,
    input  wire logic                     tx_end_event,
    output var  logic                     cmd_accept_a,
    output var  logic                     cmd_accept_b,
    output var  logic                     status_instrumentation,
    output var  logic                     status_service_request,
    output var  logic                     status_broadcast,
    output var  logic                     status_busy,
    output var  logic                     status_subsystem_flag,
    output var  logic                     status_terminal_flag,
    output var  logic [7:0]               status_a_bits,
    output var  logic                     selftest_enable,
    output var  logic                     selftest_channel_sel,
    output var  logic                     message_end_irq_n,
    output var  logic [15:6]              base_pointer_block,
    output var  logic                     base_pointer_single_buf,
    output var  logic [3:0]               base_pointer_buf_size,
    output var  logic                     irq
);
    import rtc_pkg::*;

    typedef struct packed {
        logic [15:0]      terminal_control;
        logic [15:0]      base_pointer;
        logic [IRQ_W-1:0] irq_mask;
        logic             bcast_seen;
        logic [31:0]      dat;
        logic             ack;
        logic             acc_a;
        logic             acc_b;
        logic             s_instrumentation_flag;
        logic             s_service_request_flag;
        logic             s_bcast;
        logic             s_busy;
        logic             s_subsys;
        logic             s_tflag;
        logic [7:0]       s_a_bits;
        logic             st_en;
        logic             st_sel;
        logic             eom_n;
        logic             irq;
    } rtc_state_t;

    rtc_state_t       state, next_state;
    logic [IRQ_W-1:0] irq_status;
    logic [IRQ_W-1:0] irq_set;
    logic [IRQ_W-1:0] irq_clr;
    logic             req;
    logic             wr_low;

    // ack takes one cycle; a new request only after ack fell
    assign req    = wb_cyc_i && wb_stb_i && !state.ack;
    assign wr_low = req && wb_we_i && wb_sel_i[0] && wb_sel_i[1];

    assign irq_set[IRQ_RX_END] = rx_end_event;
    assign irq_set[IRQ_TX_END] = tx_end_event;
    assign irq_set[IRQ_BCAST]  = broadcast_rx;
    assign irq_clr = (wr_low && wb_adr_i == OFF_IRQ_STATUS) ? wb_dat_i[IRQ_W-1:0] : '0;

    genvar gi;
    generate
        for (gi = 0; gi < IRQ_W; gi++) begin : g_sticky
            rtc_sticky_bit u_bit (
                .clk_sys   (clk_sys),
                .rst_n     (rst_n),
                .set_pulse (irq_set[gi]),
                .clr_pulse (irq_clr[gi]),
                .flag      (irq_status[gi])
            );
        end
    endgenerate

    always_comb begin
        logic [15:0] ctl;
        logic        mode_b;
        next_state     = state;
        ctl            = state.terminal_control;
        mode_b         = !protocol_select;
        next_state.ack = req;
        next_state.dat = 32'h0000_0000;
        // control and base pointer take 16 bits, irq mask 3; both low byte lanes must be selected
        if (wr_low) begin
            unique case (wb_adr_i)
                OFF_CONTROL: begin
                    next_state.terminal_control = wb_dat_i[15:0];
                end
                OFF_BASE_PTR: begin
                    next_state.base_pointer = wb_dat_i[15:0] & BASE_PTR_MASK;
                end
                OFF_IRQ_MASK: begin
                    next_state.irq_mask = wb_dat_i[IRQ_W-1:0];
                end
                default: begin
                end
            endcase
        end
        if (req && !wb_we_i) begin
            unique case (wb_adr_i)
                OFF_CONTROL:    next_state.dat = {16'h0000, state.terminal_control};
                OFF_BASE_PTR:   next_state.dat = {16'h0000, state.base_pointer};
                OFF_IRQ_STATUS: next_state.dat = {29'h0, irq_status};
                OFF_IRQ_MASK:   next_state.dat = {29'h0, state.irq_mask};
                default:        next_state.dat = 32'h0000_0000;
            endcase
        end
        // broadcast command latches until the next non-broadcast command
        if (broadcast_rx) begin
            next_state.bcast_seen = 1'b1;
        end else if (cmd_valid_a || cmd_valid_b) begin
            next_state.bcast_seen = 1'b0;
        end
        next_state.acc_a = cmd_valid_a && ctl[BIT_CHA_EN];
        next_state.acc_b = cmd_valid_b && ctl[BIT_CHB_EN];
        // reserved bits 7,6,5,1 reach no status output in this layout
        next_state.s_instrumentation_flag  = mode_b && ctl[BIT_INSTRUMENTATION_FLAG];
        next_state.s_service_request_flag  = mode_b && ctl[BIT_SERVICE_REQUEST_FLAG];
        next_state.s_bcast  = mode_b && (ctl[BIT_BCAST] || state.bcast_seen);
        next_state.s_busy   = mode_b && ctl[BIT_BUSY];
        next_state.s_subsys = mode_b && ctl[BIT_SUBSYS];
        next_state.s_tflag  = ctl[BIT_TFLAG];
        // other layout passes bits 9..2 as raw status bits
        next_state.s_a_bits = mode_b ? 8'h00 : ctl[9:2];
        next_state.st_en    = ctl[BIT_ST_EN];
        next_state.st_sel   = ctl[BIT_ST_SEL];
        next_state.eom_n    = !((rx_end_event && ctl[BIT_RX_MASK]) ||
                                (tx_end_event && ctl[BIT_TX_MASK]));
        next_state.irq      = |(irq_status & state.irq_mask);
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state                  <= '0;
            state.terminal_control <= CONTROL_RESET;
            state.base_pointer     <= BASE_PTR_RESET;
            state.irq_mask         <= IRQ_RESET;
            state.eom_n            <= 1'b1;
        end else begin
            state <= next_state;
        end
    end

    assign wb_dat_o                = state.dat;
    assign wb_ack_o                = state.ack;
    assign cmd_accept_a            = state.acc_a;
    assign cmd_accept_b            = state.acc_b;
    assign status_instrumentation  = state.s_instrumentation_flag;
    assign status_service_request  = state.s_service_request_flag;
    assign status_broadcast        = state.s_bcast;
    assign status_busy             = state.s_busy;
    assign status_subsystem_flag   = state.s_subsys;
    assign status_terminal_flag    = state.s_tflag;
    assign status_a_bits           = state.s_a_bits;
    assign selftest_enable         = state.st_en;
    assign selftest_channel_sel    = state.st_sel;
    assign message_end_irq_n       = state.eom_n;
    assign base_pointer_block      = state.base_pointer[15:6];
    assign base_pointer_single_buf = state.base_pointer[4];
    assign base_pointer_buf_size   = state.base_pointer[3:0];
    assign irq                     = state.irq;
endmodule : rtc_control_reg
`default_nettype wire

/* File: rtl/rtc_pkg.sv */
// How it works
// - bit 9 sets status instrumentation bit
// - bit 8 sets status service request bit
// - bits 7,6,5,1 never touch status word
// - bit 4 forces broadcast bit, not cleared
// - received broadcast command also sets broadcast bit
// - bit 3 sets status busy bit
// - bit 2 sets status subsystem flag bit
// - bits 13,12,0 same as other layout
// - bits 11,10 are end interrupt masks; reset zero
// - base pointer holds block, buffer mode, size
// - disabled channel accepts no commands, but they still set or clear broadcast bit
// - self-test select one means channel A
// - masks gate receive/transmit end interrupts
// - protocol select low means this layout
`default_nettype none
package rtc_pkg;
    localparam int          ADDR_W          = 4;
    localparam logic [3:0]  OFF_CONTROL     = 4'h0;
    localparam logic [3:0]  OFF_BASE_PTR    = 4'h4;
    localparam logic [3:0]  OFF_IRQ_STATUS  = 4'h8;
    localparam logic [3:0]  OFF_IRQ_MASK    = 4'hC;
    localparam logic [15:0] CONTROL_RESET   = 16'h0000;
    localparam logic [15:0] BASE_PTR_RESET  = 16'h0000;
    localparam logic [15:0] BASE_PTR_MASK   = 16'hFFDF;
    localparam int          BIT_CHA_EN      = 15;
    localparam int          BIT_CHB_EN      = 14;
    localparam int          BIT_ST_EN       = 13;
    localparam int          BIT_ST_SEL      = 12;
    localparam int          BIT_RX_MASK     = 11;
    localparam int          BIT_TX_MASK     = 10;
    localparam int          BIT_INSTRUMENTATION_FLAG       = 9;
    localparam int          BIT_SERVICE_REQUEST_FLAG       = 8;
    localparam int          BIT_BCAST       = 4;
    localparam int          BIT_BUSY        = 3;
    localparam int          BIT_SUBSYS      = 2;
    localparam int          BIT_TFLAG       = 0;
    localparam int          IRQ_W           = 3;
    localparam int          IRQ_RX_END      = 0;
    localparam int          IRQ_TX_END      = 1;
    localparam int          IRQ_BCAST       = 2;
    localparam logic [2:0]  IRQ_RESET       = 3'h0;
endpackage : rtc_pkg
`default_nettype wire

/* File: rtl/rtc_sticky_bit.sv */
`timescale 1ns/10ps
`default_nettype none
module rtc_sticky_bit (
    input  wire logic clk_sys,
    input  wire logic rst_n,
    input  wire logic set_pulse,
    input  wire logic clr_pulse,
    output var  logic flag
);
    import rtc_pkg::*;
    typedef struct packed {
        logic flag;
    } rtc_sticky_t;
    rtc_sticky_t state, next_state;
    always_comb begin
        next_state = state;
        // set wins over a clear in the same cycle
        if (set_pulse) begin
            next_state.flag = 1'b1;
        end else if (clr_pulse) begin
            next_state.flag = 1'b0;
        end
    end
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end
    assign flag = state.flag;
endmodule : rtc_sticky_bit
`default_nettype wire

/* File: verif/rtc_properties.sv */
`timescale 1ns/10ps
`default_nettype none
module rtc_properties (
    input wire logic                        clk_sys,
    input wire logic                        rst_n,
    input wire logic                        wb_we_i,
    input wire logic [rtc_pkg::ADDR_W-1:0]  wb_adr_i,
    input wire logic [3:0]                  wb_sel_i,
    input wire logic [31:0]                 wb_dat_i,
    input wire logic                        wb_ack_o,
    input wire logic                        protocol_select,
    input wire logic                        cmd_valid_a,
    input wire logic                        broadcast_rx,
    input wire logic                        rx_end_event,
    input wire logic                        tx_end_event,
    input wire logic                        cmd_accept_a,
    input wire logic                        status_instrumentation,
    input wire logic                        status_service_request,
    input wire logic                        status_broadcast,
    input wire logic                        status_busy,
    input wire logic                        status_subsystem_flag,
    input wire logic                        status_terminal_flag,
    input wire logic [7:0]                  status_a_bits,
    input wire logic                        message_end_irq_n
);
    import rtc_pkg::*;
    // write to control seen at its ack edge
    wire ctl_wr = wb_ack_o && wb_we_i && wb_adr_i == OFF_CONTROL && wb_sel_i[1:0] == 2'h3;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    AST_STATUS_FOLLOW: assert property (ctl_wr && !protocol_select |=>
        {status_instrumentation, status_service_request, status_busy, status_subsystem_flag}
        == $past({wb_dat_i[9], wb_dat_i[8], wb_dat_i[3], wb_dat_i[2]})) else $error("status lag");
    AST_TFLAG_FOLLOW: assert property (
        ctl_wr |=> status_terminal_flag == $past(wb_dat_i[0])) else $error("tflag lag");
    AST_BCAST_OVERRIDE: assert property (
        ctl_wr && wb_dat_i[4] && !protocol_select |=> status_broadcast) else $error("override");
    AST_BCAST_RX: assert property (
        broadcast_rx && !protocol_select |-> ##2 status_broadcast) else $error("bcast rx");
    AST_ACCEPT_CAUSE: assert property (
        cmd_accept_a |-> $past(cmd_valid_a)) else $error("accept without command");
    AST_EOM_CAUSE: assert property (
        !message_end_irq_n |-> $past(rx_end_event || tx_end_event)) else $error("stray eom");
    AST_RESERVED_QUIET: assert property (
        !protocol_select && $past(!protocol_select) |-> status_a_bits == 8'h00) else $error("a bits");
    AST_A_MODE_QUIET: assert property (
        protocol_select && $past(protocol_select) |-> !status_busy && !status_instrumentation)
        else $error("b bits in a mode");
endmodule : rtc_properties
bind rtc_control_reg rtc_properties i_rtc_properties (.clk_sys, .rst_n, .wb_we_i, .wb_adr_i,
    .wb_sel_i, .wb_dat_i, .wb_ack_o, .protocol_select, .cmd_valid_a, .broadcast_rx, .rx_end_event,
    .tx_end_event, .cmd_accept_a, .status_instrumentation, .status_service_request,
    .status_broadcast, .status_busy, .status_subsystem_flag, .status_terminal_flag,
    .status_a_bits, .message_end_irq_n);
`default_nettype wire

/* File: verif/rtc_bc_model.sv */
`timescale 1ns/10ps
`default_nettype none
module rtc_bc_model (
    input  wire logic clk_sys,
    output var  logic cmd_valid_a,
    output var  logic cmd_valid_b,
    output var  logic broadcast_rx
);
    // one-cycle command pulses; send itself leaves at least one idle cycle before the next pulse
    initial begin
        {cmd_valid_a, cmd_valid_b, broadcast_rx} = 3'h0;
    end
    task automatic send(input logic on_b, input logic bcast);
        @(posedge clk_sys);
        {cmd_valid_a, cmd_valid_b, broadcast_rx} <= {!on_b, on_b, bcast};
        @(posedge clk_sys);
        {cmd_valid_a, cmd_valid_b, broadcast_rx} <= 3'h0;
    endtask : send
endmodule : rtc_bc_model
`default_nettype wire

/* File: verif/testbench.sv */
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import rtc_pkg::*;
    logic        clk_sys = 1'b0, rst_n = 1'b0, protocol_select = 1'b0;
    logic        wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic        rx_end_event = 1'b0, tx_end_event = 1'b0;
    logic [3:0]  wb_adr_i = 4'h0, wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rdat;
    logic        wb_ack_o, cmd_valid_a, cmd_valid_b, broadcast_rx, cmd_accept_a, cmd_accept_b;
    logic        status_instrumentation, status_service_request, status_broadcast, status_busy;
    logic        status_subsystem_flag, status_terminal_flag, selftest_enable, selftest_channel_sel;
    logic        message_end_irq_n, irq;
    logic [7:0]  status_a_bits;
    logic [15:6] base_pointer_block;
    logic        base_pointer_single_buf;
    logic [3:0]  base_pointer_buf_size;
    int          miscompares = 0, comparisons = 0, cycles = 0;
    always #2.5 clk_sys = ~clk_sys;
    rtc_control_reg i_rtc_control_reg (.clk_sys, .rst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
        .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .protocol_select, .cmd_valid_a, .cmd_valid_b,
        .broadcast_rx, .rx_end_event, .tx_end_event, .cmd_accept_a, .cmd_accept_b,
        .status_instrumentation, .status_service_request, .status_broadcast, .status_busy,
        .status_subsystem_flag, .status_terminal_flag, .status_a_bits, .selftest_enable,
        .selftest_channel_sel, .message_end_irq_n, .base_pointer_block,
        .base_pointer_single_buf, .base_pointer_buf_size, .irq);
    rtc_bc_model i_rtc_bc_model (.clk_sys, .cmd_valid_a, .cmd_valid_b, .broadcast_rx);
    task chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task bus(input logic w, input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_sys);
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} <= {2'h3, w, a, 4'hF, 16'h0, d};
        // ack and read data are taken at the same rising edge
        do @(posedge clk_sys); while (wb_ack_o !== 1'b1);
        rdat = wb_dat_o;
        {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'h0;
    endtask : bus
    task settle;
        repeat (2) @(negedge clk_sys);
    endtask : settle
    task ev(input logic rx, input logic tx);
        @(posedge clk_sys);
        {rx_end_event, tx_end_event} <= {rx, tx};
        @(posedge clk_sys);
        {rx_end_event, tx_end_event} <= 2'h0;
        @(negedge clk_sys);
    endtask : ev
    task t_ctl_bits;
        logic [15:0] d;
        chk({message_end_irq_n, irq, status_broadcast, selftest_enable}, 32'h8);
        for (int i = 0; i < 16; i++) begin
            d = 16'h0001 << i;
            bus(1'b1, OFF_CONTROL, d);
            settle;
            chk({status_instrumentation, status_service_request, status_broadcast, status_busy,
                status_subsystem_flag, status_terminal_flag}, {d[9], d[8], d[4:2], d[0]});
            chk({selftest_enable, selftest_channel_sel, status_a_bits}, {d[13:12], 8'h00});
            bus(1'b0, OFF_CONTROL, 16'h0000);
            chk(rdat, {16'h0, d});
        end
        @(posedge clk_sys);
        protocol_select <= 1'b1;
        bus(1'b1, OFF_CONTROL, 16'h0200);
        settle;
        chk({status_instrumentation, status_a_bits}, 32'h80);
        @(posedge clk_sys);
        protocol_select <= 1'b0;
        $display("control bits test done");
    endtask : t_ctl_bits
    task t_channels;
        for (int k = 0; k < 4; k++) begin
            bus(1'b1, OFF_CONTROL, {k[1:0], 14'h0000});
            for (int c = 0; c < 2; c++) begin
                i_rtc_bc_model.send(c[0], 1'b0);
                @(negedge clk_sys);
                chk({cmd_accept_a, cmd_accept_b}, c ? {1'b0, k[0]} : {k[1], 1'b0});
            end
        end
        bus(1'b1, OFF_CONTROL, 16'h0000);
        bus(1'b1, OFF_CONTROL, 16'h3000);
        settle;
        chk({selftest_enable, selftest_channel_sel}, 32'h3);
        $display("channel test done");
    endtask : t_channels
    task t_bcast;
        bus(1'b1, OFF_CONTROL, 16'hC000);
        i_rtc_bc_model.send(1'b0, 1'b1);
        settle;
        chk(status_broadcast, 32'h1);
        bus(1'b1, OFF_CONTROL, 16'hC010);
        i_rtc_bc_model.send(1'b1, 1'b0);
        settle;
        chk(status_broadcast, 32'h1);
        $display("broadcast test done");
    endtask : t_bcast
    task t_irq;
        bus(1'b1, OFF_CONTROL, 16'h0800);
        ev(1'b1, 1'b0);
        chk(message_end_irq_n, 32'h0);
        ev(1'b0, 1'b1);
        chk({message_end_irq_n, irq}, 32'h2);
        bus(1'b1, OFF_IRQ_MASK, 16'h0002);
        settle;
        chk(irq, 32'h1);
        bus(1'b1, OFF_IRQ_STATUS, 16'h0002);
        settle;
        chk(irq, 32'h0);
        bus(1'b0, OFF_IRQ_STATUS, 16'h0000);
        // broadcast seen earlier still sits in status bit 2
        chk(rdat, 32'h5);
        $display("interrupt test done");
    endtask : t_irq
    task t_base;
        bus(1'b0, OFF_BASE_PTR, 16'h0000);
        chk(rdat, 32'h0);
        bus(1'b1, OFF_BASE_PTR, 16'hFFFF);
        bus(1'b0, OFF_BASE_PTR, 16'h0000);
        chk(rdat, 32'hFFDF);
        chk({base_pointer_block, base_pointer_single_buf, base_pointer_buf_size}, 32'h7FFF);
        bus(1'b0, 4'h2, 16'h0000);
        chk(rdat, 32'h0);
        $display("base pointer test done");
    endtask : t_base
    task summarize;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : summarize
    // ceiling well above the few hundred cycles the tests need
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            miscompares++;
            summarize;
        end
    end
    initial begin
        repeat (10) @(posedge clk_sys);
        rst_n <= 1'b1;
        t_base;
        t_ctl_bits;
        t_channels;
        t_bcast;
        t_irq;
        summarize;
    end
endmodule : testbench
`default_nettype wire
